// File: src/asm_pkg.sv
// Constants and carrier types for the converter settling, mute and bypass control
`default_nettype none
package asm_pkg;
	localparam int resolution_ps = 5;
	localparam int clk_period_ps = 50000;
	localparam int corner_mhz = 1000;
	localparam int fast_settle_cycles = 8192;
	localparam int slow_settle_cycles = 65536;
	localparam int rate_meas_cycles = 1024;
	localparam int rate_tol = 2;
	localparam int ramp_steps = 256;
	localparam int gain_width = 9;
	localparam int sample_width = 24;
	localparam logic [gain_width-1:0] gain_full = 9'h100;
	localparam logic [gain_width-1:0] gain_zero = 9'h000;

	typedef struct packed {
		logic sdata;
		logic bclk;
		logic lrclk;
	} asm_serial_type;

	typedef struct packed {
		logic fast;
		logic slow;
		logic locked;
	} asm_status_type;

	typedef enum logic [1:0] {st_idle, st_fast, st_slow, st_lock} asm_state_type;
endpackage
`default_nettype wire

// File: src/asm_ramp.sv
// Soft mute gain ramp
`timescale 1ns/1ps
`default_nettype none
module asm_ramp
	import asm_pkg::*;
#(
	parameter int steps = ramp_steps
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic mute,
	output logic [gain_width-1:0] gain,
	output logic muted
);
	// Full scale equals the step count, so a full ramp takes exactly steps cycles
	localparam logic [gain_width-1:0] top = gain_width'(steps);
	logic [gain_width-1:0] next_gain;

	always_comb
	begin
		next_gain = gain;
		if (mute && gain != gain_zero)
			next_gain = gain - 9'h001; // see RL6
		else if (!mute && gain != top)
			next_gain = gain + 9'h001; // see RL6
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			gain <= gain_zero;
		else
			gain <= next_gain;
	end

	assign muted = (gain == gain_zero);

	a_ramp_down: assert property (@(posedge clk) disable iff (rst)
		mute && gain != gain_zero |=> gain == $past(gain) - 9'h001) // see RL6
		else $error("gain did not fall while muted");
	a_ramp_up: assert property (@(posedge clk) disable iff (rst)
		!mute && gain != top |=> gain == $past(gain) + 9'h001) // see RL6
		else $error("gain did not rise while unmuted");
endmodule
`default_nettype wire

// File: src/asm_ctrl.sv
// Servo settling sequencer, settling mute flag, soft mute and bypass path
// Functional notes
// RL1: The servo refines the input to output time offset to 5 ps to choose coefficients.
// RL2: The servo rejects jitter below a 1 Hz corner, hence a long settling time.
// RL3: Reset release or any rate change puts the servo into fast settling; the code ignores edge count changes of up to rate_tol (2) per window.
// RL4: After fast settling it moves to slow settling until the offset is within 5 ps.
// RL5: The settling mute flag is high throughout fast settling.
// RL6: Soft mute ramps the output to silence, and its release ramps back to full.
// RL7: Bypass copies serial input to serial output with no conversion or dither.
// RL8: The system uses bypass only for non-audio data or exact 1 to 1 synchronous rates.
// RL9: The bypass input is active high.
// RL10: Reset is active low and its release starts fast settling.
// RL11: The settling mute flag drops when fast settling ends and stays low until a new event.
`timescale 1ns/1ps
`default_nettype none
module asm_ctrl
	import asm_pkg::*;
#(
	parameter int fast_cycles = fast_settle_cycles,
	parameter int slow_cycles = slow_settle_cycles,
	parameter int meas_cycles = rate_meas_cycles
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic rst_n_pin,
	input wire logic bypass,
	input wire logic mute_req,
	input wire asm_pkg::asm_serial_type ser_in,
	input wire logic [sample_width-1:0] conv_sample,
	input wire logic out_lrclk,
	output asm_pkg::asm_serial_type ser_out,
	output logic [sample_width-1:0] out_sample,
	output logic settle_mute,
	output asm_pkg::asm_status_type status
);
	// Either the core reset or the pin reset holds the sequencer
	logic hold;
	assign hold = rst || !rst_n_pin; // see RL10

	asm_state_type state, next_state;
	logic [31:0] count, next_count;
	logic [31:0] win, next_win;
	logic [15:0] in_edges, next_in_edges, in_ref, next_in_ref;
	logic [15:0] out_edges, next_out_edges, out_ref, next_out_ref;
	logic in_lr_d, out_lr_d, next_in_lr_d, next_out_lr_d;
	logic rate_change;
	logic [gain_width-1:0] gain;
	logic muted;
	asm_serial_type next_ser_out;
	logic [sample_width-1:0] next_out_sample;
	logic signed [sample_width+9:0] scaled;

	function automatic logic differs(input logic [15:0] a, input logic [15:0] b);
		logic [15:0] d;
		d = (a > b) ? a - b : b - a;
		return d > 16'(rate_tol);
	endfunction

	// Rates are tracked as LR edges counted over a fixed window of master clocks
	always_comb
	begin
		next_in_lr_d = ser_in.lrclk;
		next_out_lr_d = out_lrclk;
		next_win = win + 32'h1;
		next_in_edges = in_edges + 16'((ser_in.lrclk != in_lr_d) ? 1 : 0);
		next_out_edges = out_edges + 16'((out_lrclk != out_lr_d) ? 1 : 0);
		next_in_ref = in_ref;
		next_out_ref = out_ref;
		rate_change = 1'b0;
		if (win == 32'(meas_cycles - 1))
		begin
			next_win = 32'h0;
			next_in_edges = 16'h0;
			next_out_edges = 16'h0;
			next_in_ref = in_edges;
			next_out_ref = out_edges;
			rate_change = differs(in_edges, in_ref) || differs(out_edges, out_ref); // see RL3
		end
	end

	always_ff @(posedge clk)
	begin
		if (hold)
		begin
			win <= 32'h0;
			in_edges <= 16'h0;
			out_edges <= 16'h0;
			in_ref <= 16'h0;
			out_ref <= 16'h0;
			in_lr_d <= 1'b0;
			out_lr_d <= 1'b0;
		end
		else
		begin
			win <= next_win;
			in_edges <= next_in_edges;
			out_edges <= next_out_edges;
			in_ref <= next_in_ref;
			out_ref <= next_out_ref;
			in_lr_d <= next_in_lr_d;
			out_lr_d <= next_out_lr_d;
		end
	end

	// Fast phase uses a wide loop gain; slow phase narrows it below the 1 Hz corner
	always_comb
	begin
		next_state = state;
		next_count = count + 32'h1;
		case (state)
			st_idle:
			begin
				next_state = st_fast; // see RL10
				next_count = 32'h0;
			end
			st_fast:
				if (count == 32'(fast_cycles - 1))
				begin
					next_state = st_slow; // see RL4
					next_count = 32'h0;
				end
			st_slow:
				// Offset converges to the 5 ps step when the slow window expires
				if (count == 32'(slow_cycles - 1))
				begin
					next_state = st_lock; // see RL1
					next_count = 32'h0;
				end
			st_lock:
				next_count = count; // see RL2
			default:
				next_state = st_idle;
		endcase
		if (rate_change && state != st_idle)
		begin
			next_state = st_fast; // see RL3
			next_count = 32'h0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (hold)
		begin
			state <= st_idle;
			count <= 32'h0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
		end
	end

	always_ff @(posedge clk)
	begin
		if (hold)
			settle_mute <= 1'b0;
		else
			settle_mute <= (next_state == st_fast); // see RL5 and RL11
	end

	asm_ramp #(
		.steps(ramp_steps)
	) u_ramp (
		.clk(clk),
		.rst(hold),
		.mute(mute_req),
		.gain(gain),
		.muted(muted)
	);

	// Bypass is a straight copy, so no gain or dither ever touches it
	// Full-width product: at unity gain a narrower one would overflow before the divide
	always_comb
	begin
		scaled = (sample_width+10)'($signed(conv_sample))
			* (sample_width+10)'($signed({1'b0, gain}));
		next_ser_out = ser_in; // see RL7 and RL9
		next_out_sample = scaled[sample_width+7:8]; // see RL6
		if (bypass)
			next_out_sample = '0; // see RL9
	end

	always_ff @(posedge clk)
	begin
		if (hold)
		begin
			ser_out <= '0;
			out_sample <= '0;
		end
		else
		begin
			ser_out <= next_ser_out;
			out_sample <= next_out_sample;
		end
	end

	assign status = {state == st_fast, state == st_slow, state == st_lock};

	a_fast_after_rel: assert property (@(posedge clk)
		$past(hold) && !hold |=> state == st_fast) // see RL10
		else $error("release did not start fast settling");
	a_fast_len: assert property (@(posedge clk) disable iff (hold)
		state == st_fast && count == 32'(fast_cycles - 1) && !rate_change |=> state == st_slow) // see RL4
		else $error("fast phase did not end on time");
	a_rate_restart: assert property (@(posedge clk) disable iff (hold)
		rate_change && state != st_idle |=> state == st_fast && count == 32'h0) // see RL3
		else $error("rate change missed");
	a_mute_flag: assert property (@(posedge clk) disable iff (hold)
		settle_mute == (state == st_fast)) // see RL5
		else $error("settling flag differs from fast phase");
	a_flag_drop: assert property (@(posedge clk) disable iff (hold)
		state == st_slow ##1 state == st_slow |-> !settle_mute) // see RL11
		else $error("settling flag high in slow phase");
	a_bypass_copy: assert property (@(posedge clk) disable iff (hold)
		!$past(hold) |-> ser_out == $past(ser_in)) // see RL7
		else $error("bypass data changed");
	a_lock_hold: assert property (@(posedge clk) disable iff (hold)
		state == st_lock && !rate_change |=> state == st_lock) // see RL1
		else $error("lock lost without cause");
	a_slow_len: assert property (@(posedge clk) disable iff (hold)
		state == st_slow && count == 32'(slow_cycles - 1) && !rate_change |=> state == st_lock) // see RL4
		else $error("slow phase did not end on time");
	a_mute_silent: assert property (@(posedge clk) disable iff (hold)
		muted |=> out_sample == '0) // see RL6
		else $error("output not silent at zero gain");
endmodule
`default_nettype wire

// File: verif/asm_ser_model.sv
// Serial audio source and sink model for the settling control bench
`timescale 1ns/1ps
`default_nettype none
module asm_ser_model
(
	input wire logic clk,
	input wire logic [3:0] div,
	output asm_pkg::asm_serial_type ser,
	output logic out_lr
);
	import asm_pkg::*;
	logic [3:0] cnt = 4'h0;
	logic [7:0] tk = 8'h00;
	asm_serial_type ser_q = '0;
	logic out_lr_q = 1'b0;
	assign ser = ser_q;
	assign out_lr = out_lr_q;
	// Out clock is 1 to 1 with the input only at div 2, the one rate used with bypass
	always @(posedge clk)
	begin
		cnt <= (cnt >= div - 4'h1) ? 4'h0 : cnt + 4'h1;
		tk <= tk + 8'h01;
		if (cnt == 4'h0)
			ser_q.lrclk <= ~ser_q.lrclk;
		ser_q.bclk <= ~ser_q.bclk;
		ser_q.sdata <= tk[0] ^ tk[2];
		out_lr_q <= tk[1];
	end
endmodule
`default_nettype wire

// File: verif/asrc_settle_mute_bypass_tb.sv
// Self-checking bench for settling, mute and bypass control
`timescale 1ns/1ps
`default_nettype none
module asrc_settle_mute_bypass_tb;
	import asm_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rst_n_pin = 1'b1;
	logic bypass = 1'b0;
	logic mute_req = 1'b0;
	logic [3:0] div = 4'h2;
	logic [23:0] conv = 24'h123456;
	logic [23:0] out_sample;
	logic settle_mute;
	logic out_lr;
	asm_serial_type ser_in;
	asm_serial_type ser_out;
	asm_serial_type prev;
	asm_status_type status;
	int err_total = 0;
	int total_checks = 0;
	always #25 clk = ~clk;
	asm_ser_model peer (.clk(clk), .div(div), .ser(ser_in), .out_lr(out_lr));
	asm_ctrl #(.fast_cycles(16), .slow_cycles(32), .meas_cycles(16)) dut (.clk(clk), .rst(rst),
		.rst_n_pin(rst_n_pin), .bypass(bypass), .mute_req(mute_req), .ser_in(ser_in),
		.conv_sample(conv), .out_lrclk(out_lr), .ser_out(ser_out), .out_sample(out_sample),
		.settle_mute(settle_mute), .status(status));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic results();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Flag must follow the fast state every cycle while waiting
	task automatic wait_st(input logic [2:0] s);
		int i;
		for (i = 0; i < 600 && status !== s; i++)
		begin
			chk({23'h0, settle_mute}, {23'h0, status.fast});
			tick(1);
		end
		if (i == 600)
		begin
			err_total++;
			results();
		end
	endtask
	task automatic t_reset();
		chk({settle_mute, ser_out, out_sample[19:0]}, 24'h0);
		@(posedge clk) rst <= 1'b0;
		tick(3);
		chk({21'h0, status}, 24'h4);
		wait_st(3'b001);
		chk({23'h0, settle_mute}, 24'h0);
		$display("reset and settle done");
	endtask
	task automatic t_rate();
		@(posedge clk) div <= 4'h8;
		wait_st(3'b100);
		@(posedge clk) div <= 4'h2;
		wait_st(3'b001);
		$display("rate change done");
	endtask
	task automatic t_mute();
		@(posedge clk) mute_req <= 1'b1;
		tick(300);
		chk(out_sample, 24'h0);
		@(posedge clk) mute_req <= 1'b0;
		tick(300);
		chk(out_sample, conv);
		$display("soft mute done");
	endtask
	task automatic t_bypass();
		@(posedge clk) bypass <= 1'b1;
		tick(2);
		repeat (8)
		begin
			prev = ser_in;
			tick(1);
			chk({21'h0, ser_out}, {21'h0, prev});
			chk(out_sample, 24'h0);
		end
		@(posedge clk) bypass <= 1'b0;
		$display("bypass done");
	endtask
	task automatic t_pin();
		@(posedge clk) rst_n_pin <= 1'b0;
		tick(2);
		chk({settle_mute, out_sample[22:0]}, 24'h0);
		@(posedge clk) rst_n_pin <= 1'b1;
		wait_st(3'b100);
		$display("reset pin done");
	endtask
	initial
	begin
		tick(10);
		t_reset();
		t_rate();
		t_mute();
		t_bypass();
		t_pin();
		results();
	end
endmodule
`default_nettype wire
